/* src/lcpt_map.svh */
// register offsets, field positions, reset values and fixed counts of the
// clock tree, modulator and panel timing block.
// assumes: included by bare name from design and bench files.
`ifndef LCPT_MAP_SVH
`define LCPT_MAP_SVH

// ----------------------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define LCPT_OFS_CLK_SEL    6'h00
`define LCPT_OFS_CLK_DIV    6'h04
`define LCPT_OFS_PWM_CTRL   6'h08
`define LCPT_OFS_PANEL_CFG  6'h0C
`define LCPT_OFS_HTOTAL     6'h10
`define LCPT_OFS_VTOTAL     6'h14
`define LCPT_OFS_HSYNC      6'h18
`define LCPT_OFS_VSYNC      6'h1C
`define LCPT_OFS_STATUS     6'h20

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LCPT_F_PIX_SRC      1:0
`define LCPT_F_MOD_SRC      5:4
`define LCPT_F_BUS_DIV      7:0
`define LCPT_F_MEM_DIV      15:8
`define LCPT_F_PIX_DIV      23:16
`define LCPT_F_MOD_DIV      31:24
`define LCPT_F_MOD_EN       0
`define LCPT_F_MOD_FORCE    1
`define LCPT_F_MOD_DUTY     15:8
`define LCPT_F_PANEL_TYPE   1:0
`define LCPT_F_PANEL_COLOR  2
`define LCPT_F_ALT_FMT      3
`define LCPT_F_WIDTH_SEL    5:4
`define LCPT_F_LINE_POL     6
`define LCPT_F_FRAME_POL    7
`define LCPT_F_TOTAL        10:0
`define LCPT_F_DISPLAY      26:16
`define LCPT_F_START        10:0
`define LCPT_F_WIDTH        26:16

// ----------------------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------------------
`define LCPT_MASK_CLK_SEL   32'h0000_0033
`define LCPT_MASK_CLK_DIV   32'hFFFF_FFFF
`define LCPT_MASK_PWM_CTRL  32'h0000_FF03
`define LCPT_MASK_PANEL     32'h0000_00FF
`define LCPT_MASK_TIMING    32'h07FF_07FF
`define LCPT_RST_CLK_SEL    32'h0000_0000
`define LCPT_RST_CLK_DIV    32'h0000_0000
`define LCPT_RST_PWM_CTRL   32'h0000_0000
`define LCPT_RST_PANEL      32'h0000_0000
`define LCPT_RST_HTOTAL     32'h00A0_00C0
`define LCPT_RST_VTOTAL     32'h00A0_00B0
`define LCPT_RST_HSYNC      32'h0008_0008
`define LCPT_RST_VSYNC      32'h0001_0001

// ----------------------------------------------------------------------------
// fixed counts and panel data widths
// ----------------------------------------------------------------------------
`define LCPT_MOD_PRESCALE_LAST 8'hFF
`define LCPT_DW_4           5'h04
`define LCPT_DW_8           5'h08
`define LCPT_DW_16          5'h10
`define LCPT_DW_9           5'h09
`define LCPT_DW_12          5'h0C
`define LCPT_DW_18          5'h12

`endif

/* src/lcpt_pkg.sv */
// types shared by the clock, modulator and panel timing block.
// assumes: nothing beyond the constants header.
package lcpt_pkg;

  typedef enum logic [1:0] {
    LCPT_PIX_SRC_A   = 2'b00,
    LCPT_PIX_SRC_B   = 2'b01,
    LCPT_PIX_SRC_BUS = 2'b10,
    LCPT_PIX_SRC_MEM = 2'b11
  } lcpt_pix_src_type;

  typedef enum logic [1:0] {
    LCPT_MOD_SRC_A   = 2'b00,
    LCPT_MOD_SRC_B   = 2'b01,
    LCPT_MOD_SRC_MEM = 2'b10,
    LCPT_MOD_SRC_PIX = 2'b11
  } lcpt_mod_src_type;

  typedef enum logic [1:0] {
    LCPT_PANEL_PASSIVE = 2'b00,
    LCPT_PANEL_ACTIVE  = 2'b01,
    LCPT_PANEL_REFLECT = 2'b10
  } lcpt_panel_type;

  typedef enum logic {
    LCPT_BUS_WAIT = 1'b0,
    LCPT_BUS_ACK  = 1'b1
  } lcpt_bus_type;

  typedef struct packed {
    logic [2:0] a_sync;
    logic [2:0] b_sync;
    logic [7:0] bus_cnt;
    logic [7:0] mem_cnt;
    logic [7:0] pix_cnt;
    logic [7:0] mod_cnt;
    logic [7:0] pre_cnt;
    logic [7:0] frame_cnt;
    logic bus_tick;
    logic mem_tick;
    logic pix_tick;
    logic mod_tick;
    logic fin_tick;
    logic [10:0] hcnt;
    logic [10:0] vcnt;
    logic line_act;
    logic frame_act;
    logic disp_en;
    logic mod_out;
    logic [4:0] dwidth;
    logic alt_fmt;
    logic [31:0] r_clk_sel;
    logic [31:0] r_clk_div;
    logic [31:0] r_pwm;
    logic [31:0] r_panel;
    logic [31:0] r_htot;
    logic [31:0] r_vtot;
    logic [31:0] r_hsync;
    logic [31:0] r_vsync;
    lcpt_bus_type bus;
    logic [31:0] rdata;
  } lcpt_state_type;

endpackage

/* src/lcpt_clock_pwm_timing.sv */
// clock tree, backlight modulator and panel sync timing of an lcd controller.
// assumes: one 50 MHz clock, avalon-mm master with waitrequest, input clocks
// from pins that run well below a quarter of ref_clk_i.
//
// The address map and the Avalon-MM register port were decided locally.
`include "lcpt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lcpt_clock_pwm_timing (
  input wire logic ref_clk_i,               // system clock, 50 MHz
  input wire logic rst_i,                   // synchronous reset, active high
  input wire logic ce_i,                    // clock enable, freezes all state
  input wire logic [5:0] avs_address_i,     // byte address
  input wire logic avs_read_i,              // read request
  input wire logic avs_write_i,             // write request
  input wire logic [3:0] avs_byteenable_i,  // write byte lanes
  input wire logic [31:0] avs_writedata_i,  // write data
  output logic [31:0] avs_readdata_o,       // read data
  output logic avs_waitrequest_o,           // slave not ready
  input wire logic input_clock_a_i,         // first input clock pin
  input wire logic input_clock_b_i,         // second input clock pin
  output logic bus_tick_o,                  // bus clock tick
  output logic mem_tick_o,                  // memory clock tick
  output logic pixel_tick_o,                // pixel clock tick
  output logic modulator_clk_o,             // final modulator clock tick
  output logic modulator_out_o,             // backlight modulator pin
  output logic line_sync_o,                 // line sync pin
  output logic frame_sync_o,                // frame sync pin
  output logic display_en_o,                // inside display period
  output logic [4:0] panel_data_width_o,    // bits per panel clock
  output logic alt_format_o                 // alternate passive format active
);

  lcpt_pkg::lcpt_state_type s_q;
  lcpt_pkg::lcpt_state_type s_d;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // derived clocks are one-cycle ticks on ref_clk_i, not real clocks, so the
  // whole tree stays in one domain at the cost of no 50% duty
  function automatic logic [8:0] div_step(input logic [7:0] cnt,
                                          input logic [7:0] ratio_m1,
                                          input logic src);
    logic [8:0] r;
    r = {1'b0, cnt};
    if (src) begin
      if (cnt >= ratio_m1) begin
        r = {1'b1, 8'h00};
      end else begin
        r = {1'b0, 8'(cnt + 8'h01)};
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be,
                                        input logic [31:0] mask);
    logic [31:0] n;
    n = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        n[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return n & mask;
  endfunction

  // ---------------------------------------------------------------------------
  // combinational next state
  // ---------------------------------------------------------------------------
  logic a_tick;
  logic b_tick;
  logic pix_src_tick;
  logic mod_src_tick;
  logic [8:0] step;
  logic [11:0] h_nd;
  logic [11:0] v_nd;
  logic line_end;
  logic mod_level;
  logic [4:0] dw;

  always_comb begin
    s_d = s_q;
    pix_src_tick = 1'b0;
    mod_src_tick = 1'b0;
    dw = `LCPT_DW_4;

    // edge taken from second and third flops, first flop feeds nothing else
    s_d.a_sync = {s_q.a_sync[1:0], input_clock_a_i};
    s_d.b_sync = {s_q.b_sync[1:0], input_clock_b_i};
    a_tick = s_q.a_sync[1] & ~s_q.a_sync[2];
    b_tick = s_q.b_sync[1] & ~s_q.b_sync[2];

    step = div_step(s_q.bus_cnt, s_q.r_clk_div[`LCPT_F_BUS_DIV], a_tick);
    s_d.bus_cnt = step[7:0];
    s_d.bus_tick = step[8];
    step = div_step(s_q.mem_cnt, s_q.r_clk_div[`LCPT_F_MEM_DIV], s_q.bus_tick);
    s_d.mem_cnt = step[7:0];
    s_d.mem_tick = step[8];

    case (lcpt_pkg::lcpt_pix_src_type'(s_q.r_clk_sel[`LCPT_F_PIX_SRC]))
      lcpt_pkg::LCPT_PIX_SRC_A: pix_src_tick = a_tick;
      lcpt_pkg::LCPT_PIX_SRC_B: pix_src_tick = b_tick;
      lcpt_pkg::LCPT_PIX_SRC_BUS: pix_src_tick = s_q.bus_tick;
      lcpt_pkg::LCPT_PIX_SRC_MEM: pix_src_tick = s_q.mem_tick;
      default: pix_src_tick = 1'b0;
    endcase
    step = div_step(s_q.pix_cnt, s_q.r_clk_div[`LCPT_F_PIX_DIV], pix_src_tick);
    s_d.pix_cnt = step[7:0];
    s_d.pix_tick = step[8];

    // ---- modulator ----
    case (lcpt_pkg::lcpt_mod_src_type'(s_q.r_clk_sel[`LCPT_F_MOD_SRC]))
      lcpt_pkg::LCPT_MOD_SRC_A: mod_src_tick = a_tick;
      lcpt_pkg::LCPT_MOD_SRC_B: mod_src_tick = b_tick;
      lcpt_pkg::LCPT_MOD_SRC_MEM: mod_src_tick = s_q.mem_tick;
      lcpt_pkg::LCPT_MOD_SRC_PIX: mod_src_tick = s_q.pix_tick;
      default: mod_src_tick = 1'b0;
    endcase
    if (s_q.r_pwm[`LCPT_F_MOD_EN]) begin
      step = div_step(s_q.mod_cnt, s_q.r_clk_div[`LCPT_F_MOD_DIV], mod_src_tick);
      s_d.mod_cnt = step[7:0];
      s_d.mod_tick = step[8];
      s_d.fin_tick = 1'b0;
      if (s_q.mod_tick) begin
        s_d.pre_cnt = 8'(s_q.pre_cnt + 8'h01);
        s_d.fin_tick = (s_q.pre_cnt == `LCPT_MOD_PRESCALE_LAST);
      end
      if (s_q.fin_tick) begin
        s_d.frame_cnt = 8'(s_q.frame_cnt + 8'h01); // wraps every 256 periods
      end
    end else begin
      // disabled modulator clears its whole chain to zero
      s_d.mod_cnt = 8'h00;
      s_d.pre_cnt = 8'h00;
      s_d.frame_cnt = 8'h00;
      s_d.mod_tick = 1'b0;
      s_d.fin_tick = 1'b0;
    end
    mod_level = s_q.r_pwm[`LCPT_F_MOD_EN] &
                (s_q.frame_cnt < s_q.r_pwm[`LCPT_F_MOD_DUTY]);
    s_d.mod_out = s_q.r_pwm[`LCPT_F_MOD_FORCE] | mod_level;

    // ---- panel data width and format ----
    if (lcpt_pkg::lcpt_panel_type'(s_q.r_panel[`LCPT_F_PANEL_TYPE]) ==
        lcpt_pkg::LCPT_PANEL_PASSIVE) begin
      case (s_q.r_panel[`LCPT_F_WIDTH_SEL])
        2'b00: dw = `LCPT_DW_4;
        2'b01: dw = `LCPT_DW_8;
        default: dw = `LCPT_DW_16;
      endcase
    end else begin
      case (s_q.r_panel[`LCPT_F_WIDTH_SEL])
        2'b00: dw = `LCPT_DW_9;
        2'b01: dw = `LCPT_DW_12;
        default: dw = `LCPT_DW_18;
      endcase
    end
    s_d.dwidth = dw;
    s_d.alt_fmt = s_q.r_panel[`LCPT_F_ALT_FMT] & s_q.r_panel[`LCPT_F_PANEL_COLOR] &
                  (s_q.r_panel[`LCPT_F_PANEL_TYPE] == 2'b00) &
                  (dw == `LCPT_DW_8);

    // ---- sync timing, one step per pixel tick ----
    h_nd = {1'b0, s_q.hcnt} - {1'b0, s_q.r_htot[`LCPT_F_DISPLAY]};
    v_nd = {1'b0, s_q.vcnt} - {1'b0, s_q.r_vtot[`LCPT_F_DISPLAY]};
    line_end = ({1'b0, s_q.hcnt} + 12'h001) >= {1'b0, s_q.r_htot[`LCPT_F_TOTAL]};
    if (s_q.pix_tick) begin
      // line is display then blanking, total is their sum
      s_d.hcnt = line_end ? 11'h000 : 11'(s_q.hcnt + 11'h001);
      if (line_end) begin
        if (({1'b0, s_q.vcnt} + 12'h001) >= {1'b0, s_q.r_vtot[`LCPT_F_TOTAL]}) begin
          s_d.vcnt = 11'h000;
        end else begin
          s_d.vcnt = 11'(s_q.vcnt + 11'h001);
        end
      end
      s_d.disp_en = (s_q.hcnt < s_q.r_htot[`LCPT_F_DISPLAY]) &&
                    (s_q.vcnt < s_q.r_vtot[`LCPT_F_DISPLAY]);
      s_d.line_act = (s_q.hcnt >= s_q.r_htot[`LCPT_F_DISPLAY]) &&
                     (h_nd >= {1'b0, s_q.r_hsync[`LCPT_F_START]}) &&
                     (h_nd < ({1'b0, s_q.r_hsync[`LCPT_F_START]} +
                              {1'b0, s_q.r_hsync[`LCPT_F_WIDTH]}));
      s_d.frame_act = (s_q.vcnt >= s_q.r_vtot[`LCPT_F_DISPLAY]) &&
                      (v_nd >= {1'b0, s_q.r_vsync[`LCPT_F_START]}) &&
                      (v_nd < ({1'b0, s_q.r_vsync[`LCPT_F_START]} +
                               {1'b0, s_q.r_vsync[`LCPT_F_WIDTH]}));
    end

    // ---- avalon slave: one wait cycle, then a single ack cycle ----
    s_d.bus = lcpt_pkg::LCPT_BUS_WAIT;
    if ((avs_read_i | avs_write_i) && s_q.bus == lcpt_pkg::LCPT_BUS_WAIT) begin
      s_d.bus = lcpt_pkg::LCPT_BUS_ACK;
      case (avs_address_i)
        `LCPT_OFS_CLK_SEL: s_d.rdata = s_q.r_clk_sel;
        `LCPT_OFS_CLK_DIV: s_d.rdata = s_q.r_clk_div;
        `LCPT_OFS_PWM_CTRL: s_d.rdata = s_q.r_pwm;
        `LCPT_OFS_PANEL_CFG: s_d.rdata = s_q.r_panel;
        `LCPT_OFS_HTOTAL: s_d.rdata = s_q.r_htot;
        `LCPT_OFS_VTOTAL: s_d.rdata = s_q.r_vtot;
        `LCPT_OFS_HSYNC: s_d.rdata = s_q.r_hsync;
        `LCPT_OFS_VSYNC: s_d.rdata = s_q.r_vsync;
        `LCPT_OFS_STATUS: s_d.rdata = {5'h00, s_q.vcnt, 3'h0, s_q.dwidth, 3'h0,
                                       s_q.alt_fmt, s_q.disp_en, s_q.frame_act,
                                       s_q.line_act, s_q.mod_out};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && s_q.bus == lcpt_pkg::LCPT_BUS_ACK) begin
      case (avs_address_i)
        `LCPT_OFS_CLK_SEL: s_d.r_clk_sel = merge(s_q.r_clk_sel, avs_writedata_i,
                                                 avs_byteenable_i, `LCPT_MASK_CLK_SEL);
        `LCPT_OFS_CLK_DIV: s_d.r_clk_div = merge(s_q.r_clk_div, avs_writedata_i,
                                                 avs_byteenable_i, `LCPT_MASK_CLK_DIV);
        `LCPT_OFS_PWM_CTRL: s_d.r_pwm = merge(s_q.r_pwm, avs_writedata_i,
                                              avs_byteenable_i, `LCPT_MASK_PWM_CTRL);
        `LCPT_OFS_PANEL_CFG: s_d.r_panel = merge(s_q.r_panel, avs_writedata_i,
                                                 avs_byteenable_i, `LCPT_MASK_PANEL);
        `LCPT_OFS_HTOTAL: s_d.r_htot = merge(s_q.r_htot, avs_writedata_i,
                                             avs_byteenable_i, `LCPT_MASK_TIMING);
        `LCPT_OFS_VTOTAL: s_d.r_vtot = merge(s_q.r_vtot, avs_writedata_i,
                                             avs_byteenable_i, `LCPT_MASK_TIMING);
        `LCPT_OFS_HSYNC: s_d.r_hsync = merge(s_q.r_hsync, avs_writedata_i,
                                             avs_byteenable_i, `LCPT_MASK_TIMING);
        `LCPT_OFS_VSYNC: s_d.r_vsync = merge(s_q.r_vsync, avs_writedata_i,
                                             avs_byteenable_i, `LCPT_MASK_TIMING);
        default: s_d.r_clk_sel = s_q.r_clk_sel;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.bus <= lcpt_pkg::LCPT_BUS_WAIT;
      s_q.dwidth <= `LCPT_DW_4;
      s_q.r_clk_sel <= `LCPT_RST_CLK_SEL;
      s_q.r_clk_div <= `LCPT_RST_CLK_DIV;
      s_q.r_pwm <= `LCPT_RST_PWM_CTRL;
      s_q.r_panel <= `LCPT_RST_PANEL;
      s_q.r_htot <= `LCPT_RST_HTOTAL;
      s_q.r_vtot <= `LCPT_RST_VTOTAL;
      s_q.r_hsync <= `LCPT_RST_HSYNC;
      s_q.r_vsync <= `LCPT_RST_VSYNC;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = (s_q.bus == lcpt_pkg::LCPT_BUS_WAIT);
  assign bus_tick_o = s_q.bus_tick;
  assign mem_tick_o = s_q.mem_tick;
  assign pixel_tick_o = s_q.pix_tick;
  assign modulator_clk_o = s_q.fin_tick;
  assign modulator_out_o = s_q.mod_out;
  // polarity applied to a flop output only, so no glitch reaches the pin
  assign line_sync_o = s_q.line_act ^ ~s_q.r_panel[`LCPT_F_LINE_POL];
  assign frame_sync_o = s_q.frame_act ^ ~s_q.r_panel[`LCPT_F_FRAME_POL];
  assign display_en_o = s_q.disp_en;
  assign panel_data_width_o = s_q.dwidth;
  assign alt_format_o = s_q.alt_fmt;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_force_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && s_q.r_pwm[`LCPT_F_MOD_FORCE]) |=> modulator_out_o)
    else $error("force-high did not drive modulator high");

  a_disabled_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !s_q.r_pwm[`LCPT_F_MOD_FORCE] && !s_q.r_pwm[`LCPT_F_MOD_EN])
      |=> !modulator_out_o)
    else $error("disabled modulator output not low");

  a_mod_chain_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !s_q.r_pwm[`LCPT_F_MOD_EN]) |=>
      (s_q.pre_cnt == 8'h00 && !s_q.mod_tick && !modulator_clk_o))
    else $error("modulator clock ran while disabled");

  a_prescale_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && s_q.r_pwm[`LCPT_F_MOD_EN] && s_q.mod_tick && s_q.pre_cnt == 8'hFF)
      |=> modulator_clk_o)
    else $error("final modulator tick missing after 256 ticks");

  a_duty_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && s_q.r_pwm[`LCPT_F_MOD_EN] && !s_q.r_pwm[`LCPT_F_MOD_FORCE]) |=>
      (modulator_out_o == ($past(s_q.frame_cnt) < $past(s_q.r_pwm[`LCPT_F_MOD_DUTY]))))
    else $error("modulator level does not match duty");

  a_bus_divide: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && s_q.a_sync[1] && !s_q.a_sync[2] &&
     s_q.bus_cnt >= s_q.r_clk_div[`LCPT_F_BUS_DIV]) |=> bus_tick_o)
    else $error("bus clock tick missing at divide count");

  a_mem_source: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !s_q.bus_tick) |=> !mem_tick_o)
    else $error("memory tick without bus tick");

  a_alt_format: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    alt_format_o |-> (panel_data_width_o == `LCPT_DW_8))
    else $error("alternate format outside 8-bit passive");

  a_width_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && s_q.r_panel[`LCPT_F_PANEL_TYPE] == 2'b00) |=>
      (panel_data_width_o inside {`LCPT_DW_4, `LCPT_DW_8, `LCPT_DW_16}))
    else $error("passive data width out of set");

  a_line_lead: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && s_q.pix_tick && s_q.hcnt >= s_q.r_htot[`LCPT_F_DISPLAY] &&
     h_nd == {1'b0, s_q.r_hsync[`LCPT_F_START]} && s_q.r_hsync[`LCPT_F_WIDTH] != 11'h000)
      |=> s_q.line_act)
    else $error("line sync did not start at programmed pixel");

endmodule

`default_nettype wire

/* verif/lcpt_panel_model.sv */
// panel model: measures sync pulse position and lengths in ref cycles.
// assumes: active low sync levels, display enable from the block.
`timescale 1ns/1ps
`default_nettype none
module lcpt_panel_model (
  input wire logic clk_i,        // ref clock
  input wire logic rst_i,        // sync reset
  input wire logic line_sync_i,  // line sync pin
  input wire logic frame_sync_i, // frame sync pin
  input wire logic display_en_i, // display period
  output var int line_start_o,   // blanking start to line pulse
  output var int line_width_o,   // last line pulse length
  output var int frame_width_o   // last frame pulse length
);
  int ds, lw, fw;
  logic de_q, ls_q, fs_q;
  always_ff @(posedge clk_i) begin
    de_q <= display_en_i;
    ls_q <= line_sync_i;
    fs_q <= frame_sync_i;
    if (rst_i) begin
      ds <= 0;
      lw <= 0;
      fw <= 0;
    end else begin
      ds <= (de_q && !display_en_i) ? 1 : ds + 1;
      lw <= line_sync_i ? 0 : lw + 1;
      fw <= frame_sync_i ? 0 : fw + 1;
      // lines in vertical blanking see no display end, so skip them
      if (ls_q && !line_sync_i && ds < 200) line_start_o <= ds;
      if (!ls_q && line_sync_i) line_width_o <= lw;
      if (!fs_q && frame_sync_i) frame_width_o <= fw;
    end
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench: register bus, clock tree, modulator, sync timing.
// assumes: panel model beside the block; input clocks made here.
`include "lcpt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i = 0, rst_i = 1, rd = 0, wr = 0, ca = 0, cb = 0;
  logic [5:0] addr = '0;
  logic [3:0] be = '0;
  logic [1:0] ka = '0, kb = '0;
  logic [31:0] wd = '0, rdata, m, old, seed = 32'h0000_0025;
  logic wt, btk, mtk, ptk, mck, mout, ls, fs, de, alt;
  logic [4:0] dw;
  logic [31:0] expq[$];
  int miscompares = 0, n_checks = 0, ls_st, ls_w, fs_w, n, i;
  int per[4] = '{8, 6, 16, 32};
  int dws[6] = '{4, 8, 16, 9, 12, 18};
  lcpt_clock_pwm_timing lcpt_clock_pwm_timing_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .input_clock_a_i(ca), .input_clock_b_i(cb), .bus_tick_o(btk),
    .mem_tick_o(mtk), .pixel_tick_o(ptk), .modulator_clk_o(mck), .modulator_out_o(mout),
    .line_sync_o(ls), .frame_sync_o(fs), .display_en_o(de), .panel_data_width_o(dw),
    .alt_format_o(alt));
  lcpt_panel_model lcpt_panel_model_inst (.clk_i(ref_clk_i), .rst_i(rst_i), .line_sync_i(ls),
    .frame_sync_i(fs), .display_en_i(de), .line_start_o(ls_st), .line_width_o(ls_w),
    .frame_width_o(fs_w));
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // input clocks: a has period 8, b period 6, both below a quarter of ref
  always @(posedge ref_clk_i) begin
    ka <= ka + 2'h1;
    kb <= (kb == 2'h2) ? 2'h0 : kb + 2'h1;
    if (ka == 2'h3) ca <= ~ca;
    if (kb == 2'h2) cb <= ~cb;
  end
  // ---------------------------------------------------------------
  // checking, bus and measuring tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // no limit of its own: only the watchdog ends a stalled access
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge ref_clk_i);
    addr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk_i);
    end while (wt !== 1'b0);
    wr <= 0;
    rd <= 0;
  endtask
  task automatic rdx(input logic [5:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    bus(0, a, 32'h0000_0000, 4'hF);
  endtask
  // counts cycles between two pulses; gives 5000 when none come
  // w: 0 pixel, 1 final modulator, 2 bus, 3 memory tick
  task automatic gap(input int w, output int c);
    repeat (2) begin
      c = 0;
      do begin
        @(posedge ref_clk_i);
        c++;
      end while (((w == 0) ? ptk : (w == 1) ? mck : (w == 2) ? btk : mtk) !== 1'b1 &&
                 c < 5000);
    end
  endtask
  always @(posedge ref_clk_i) begin
    if (rd && wt === 1'b0 && expq.size() > 0) chk(rdata, expq.pop_front());
  end
  initial begin
    #(20 * 90000);
    miscompares++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 0;
    chk(mout, 1'b0);
    chk(dw, `LCPT_DW_4);
    rdx(`LCPT_OFS_HTOTAL, `LCPT_RST_HTOTAL);
    rdx(`LCPT_OFS_VSYNC, `LCPT_RST_VSYNC);
    rdx(6'h24, 32'h0000_0000);
    old = `LCPT_RST_HSYNC;
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      m = {{8{seed[3]}}, {8{seed[2]}}, {8{seed[1]}}, {8{seed[0]}}};
      bus(1, `LCPT_OFS_HSYNC, seed, seed[3:0]);
      old = ((old & ~m) | (seed & m)) & `LCPT_MASK_TIMING;
      rdx(`LCPT_OFS_HSYNC, old);
    end
    bus(1, `LCPT_OFS_CLK_DIV, 32'h0000_0101, 4'hF);
    gap(2, n);
    chk(n, 16);
    gap(3, n);
    chk(n, 32);
    for (i = 0; i < 4; i++) begin
      bus(1, `LCPT_OFS_CLK_SEL, i, 4'hF);
      gap(0, n);
      chk(n, per[i]);
    end
    bus(1, `LCPT_OFS_CLK_DIV, 32'h0002_0101, 4'hF);
    bus(1, `LCPT_OFS_CLK_SEL, 32'h0000_0010, 4'hF);
    gap(0, n);
    chk(n, 24);
    bus(1, `LCPT_OFS_CLK_DIV, 32'h0000_0000, 4'hF);
    // 32 display pixels suit the passive width steps of 4, 8 and 16 bits, not the active 9, 12 and 18
    bus(1, `LCPT_OFS_HTOTAL, 32'h0020_0030, 4'hF);
    bus(1, `LCPT_OFS_VTOTAL, 32'h0004_0008, 4'hF);
    bus(1, `LCPT_OFS_HSYNC, 32'h0003_0002, 4'hF);
    bus(1, `LCPT_OFS_VSYNC, 32'h0001_0001, 4'hF);
    repeat (6000) @(posedge ref_clk_i);
    chk(ls_st, 16);
    chk(ls_w, 24);
    chk(fs_w, 384);
    bus(1, `LCPT_OFS_PWM_CTRL, 32'h0000_8001, 4'hF);
    gap(1, n);
    chk(n, 1536);
    chk(mout, 1'b1);
    bus(1, `LCPT_OFS_PWM_CTRL, 32'h0000_0001, 4'hF);
    gap(1, n);
    chk(mout, 1'b0);
    bus(1, `LCPT_OFS_PWM_CTRL, 32'h0000_0002, 4'hF);
    gap(1, n);
    chk(n, 5000);
    chk(mout, 1'b1);
    bus(1, `LCPT_OFS_PWM_CTRL, 32'h0000_0000, 4'hF);
    repeat (4) @(posedge ref_clk_i);
    chk(mout, 1'b0);
    for (i = 0; i < 6; i++) begin
      n = i % 3;
      bus(1, `LCPT_OFS_PANEL_CFG, {26'h0, n[1:0], 3'b110, i >= 3}, 4'hF);
      repeat (2) @(posedge ref_clk_i);
      chk(dw, dws[i]);
      chk(alt, i == 1);
    end
    // both pulses active high: idle level inside the display period is low
    bus(1, `LCPT_OFS_PANEL_CFG, 32'h0000_00C0, 4'hF);
    do begin
      @(posedge ref_clk_i);
    end while (de !== 1'b1);
    chk(ls, 1'b0);
    chk(fs, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
